// file: core/cca_defs.vh
// Constants of the counter array with six capture/compare modules.
// Assumes an 8-bit special-function register port and one core clock.
// How it works
// - Width select picks 16-bit or 8-bit modulation
// - Comparator enable turns module comparison on
// - Rising capture only while its enable set
// - Falling capture only while its enable set
// - Match enable sets module flag on equality
// - Toggle enable inverts output pin on match
// - Toggle plus modulation means frequency output
// - Modulation enable drives modulated output waveform
// - Flag request raised only when irq enabled
// - Six mode registers, read/write, reset zero
// - Counter readable/writable as two bytes, reset zero
// - Compare value held as two byte registers
// - Hardware only sets flags, software clears
// - Overflow flag set on wrap to zero
// - Watchdog enable turns module five into watchdog
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH

// ************************************************
// Register addresses
// ************************************************
`define CCA_CN_ADDR 8'hD8
`define CCA_MD_ADDR 8'hD9
`define CCA_CNT_LO_ADDR 8'hF9
`define CCA_CNT_HI_ADDR 8'hFA
`define CCA_MODE0_ADDR 8'hDA
`define CCA_MODE1_ADDR 8'hDB
`define CCA_MODE2_ADDR 8'hDC
`define CCA_MODE3_ADDR 8'hDD
`define CCA_MODE4_ADDR 8'hDE
`define CCA_MODE5_ADDR 8'hCE
`define CCA_LO0_ADDR 8'hFB
`define CCA_LO1_ADDR 8'hE9
`define CCA_LO2_ADDR 8'hEB
`define CCA_LO3_ADDR 8'hED
`define CCA_LO4_ADDR 8'hFD
`define CCA_LO5_ADDR 8'hD2
`define CCA_HI0_ADDR 8'hFC
`define CCA_HI1_ADDR 8'hEA
`define CCA_HI2_ADDR 8'hEC
`define CCA_HI3_ADDR 8'hEE
`define CCA_HI4_ADDR 8'hFE
`define CCA_HI5_ADDR 8'hD3

// ************************************************
// Field positions
// ************************************************
`define CCA_WIDE_BIT 7
`define CCA_CMP_EN_BIT 6
`define CCA_RISE_BIT 5
`define CCA_FALL_BIT 4
`define CCA_MATCH_BIT 3
`define CCA_TOG_BIT 2
`define CCA_PWM_BIT 1
`define CCA_IRQ_EN_BIT 0
`define CCA_CF_BIT 7
`define CCA_CR_BIT 6
`define CCA_WATCHDOG_ENABLE_BIT 6
`define CCA_WDLCK_BIT 5
`define CCA_ECF_BIT 0

// ************************************************
// Reset values and timing counts
// ************************************************
`define CCA_MODE_RST 8'h00
`define CCA_BYTE_RST 8'h00
`define CCA_MD_RST 8'h40
`define CCA_CNT_RST 16'h0000
`define CCA_DIV12_LAST 4'hB
`define CCA_DIV4_LAST 4'h3
`define CCA_TB_DIV12 3'h0
`define CCA_TB_DIV4 3'h1
`define CCA_TB_EXT 3'h3
`define CCA_TB_SYS 3'h4
`define CCA_NO_IDX 3'h7

`endif

// file: core/cca_top.v
// Counter array: 16-bit timebase counter, six capture/compare modules,
// control/mode registers and the module five watchdog.
// Assumes a single-cycle register port on core_clk; pins are asynchronous.
`timescale 1ns/1ps
`include "cca_defs.vh"

module cca_top (
	input wire core_clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata_q,
	input wire [5:0] module_input,
	input wire ext_count_in,
	output reg [5:0] module_output_pin,
	output reg irq_q,
	output reg wdt_reset_q
);

	// ************************************************
	// Address decode helpers
	// ************************************************

	// Mode register address to module index
	function [2:0] mode_idx;
		input [7:0] a;
		begin
			case (a)
				`CCA_MODE0_ADDR: mode_idx = 3'h0;
				`CCA_MODE1_ADDR: mode_idx = 3'h1;
				`CCA_MODE2_ADDR: mode_idx = 3'h2;
				`CCA_MODE3_ADDR: mode_idx = 3'h3;
				`CCA_MODE4_ADDR: mode_idx = 3'h4;
				`CCA_MODE5_ADDR: mode_idx = 3'h5;
				default: mode_idx = `CCA_NO_IDX;
			endcase
		end
	endfunction

	// Compare low byte address to module index
	function [2:0] lo_idx;
		input [7:0] a;
		begin
			case (a)
				`CCA_LO0_ADDR: lo_idx = 3'h0;
				`CCA_LO1_ADDR: lo_idx = 3'h1;
				`CCA_LO2_ADDR: lo_idx = 3'h2;
				`CCA_LO3_ADDR: lo_idx = 3'h3;
				`CCA_LO4_ADDR: lo_idx = 3'h4;
				`CCA_LO5_ADDR: lo_idx = 3'h5;
				default: lo_idx = `CCA_NO_IDX;
			endcase
		end
	endfunction

	// Compare high byte address to module index
	function [2:0] hi_idx;
		input [7:0] a;
		begin
			case (a)
				`CCA_HI0_ADDR: hi_idx = 3'h0;
				`CCA_HI1_ADDR: hi_idx = 3'h1;
				`CCA_HI2_ADDR: hi_idx = 3'h2;
				`CCA_HI3_ADDR: hi_idx = 3'h3;
				`CCA_HI4_ADDR: hi_idx = 3'h4;
				`CCA_HI5_ADDR: hi_idx = 3'h5;
				default: hi_idx = `CCA_NO_IDX;
			endcase
		end
	endfunction

	// ************************************************
	// Declarations
	// ************************************************
	reg [6:0] in_s1_q; // First stage, read by second only
	reg [6:0] in_s2_q; // Second stage
	reg [6:0] in_s3_q; // Third stage
	reg [6:0] in_lvl_q; // Settled level after agreement
	reg [7:0] md_q; // Timebase and watchdog control
	reg cf_q; // Counter overflow flag
	reg cr_q; // Counter run control
	reg [5:0] flag_q; // Module event flags
	reg [3:0] div_q; // System clock prescaler
	reg [15:0] cnt_q; // The timebase counter
	reg tick_q; // Counter moved last cycle
	reg ovf_q; // Full wrap last cycle
	reg lo_ovf_q; // Low byte wrap last cycle
	reg [7:0] rd_d; // Read data mux
	wire [6:0] rise; // Settled rising edges
	wire [6:0] fall; // Settled falling edges
	wire [2:0] tb_sel; // Timebase select field
	wire [3:0] div_last; // Prescaler terminal value
	wire watchdog_enable; // Module five is the watchdog
	wire tick; // Counter increments this cycle
	wire [47:0] mode_all; // All mode registers
	wire [47:0] lo_all; // All compare low bytes
	wire [47:0] hi_all; // All compare high bytes
	wire [5:0] flag_set; // Module events this cycle
	wire [5:0] irq_en; // Effective flag interrupt enables
	wire [5:0] out_d; // Next pin levels
	wire [2:0] rd_m; // Read decode, mode
	wire [2:0] rd_l; // Read decode, low byte
	wire [2:0] rd_h; // Read decode, high byte

	// ************************************************
	// Input synchronisers
	// ************************************************

	// Three stages; a level counts once stages two and three agree
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_s1_q <= 7'h00;
			in_s2_q <= 7'h00;
			in_s3_q <= 7'h00;
			in_lvl_q <= 7'h00;
		end else begin
			in_s1_q <= {ext_count_in, module_input};
			in_s2_q <= in_s1_q;
			in_s3_q <= in_s2_q;
			// Keep old level while stages disagree
			in_lvl_q <= (in_s2_q & in_s3_q) | (in_lvl_q & (in_s2_q | in_s3_q));
		end
	end

	assign rise = in_s2_q & in_s3_q & ~in_lvl_q;
	assign fall = ~in_s2_q & ~in_s3_q & in_lvl_q;

	// ************************************************
	// Timebase
	// ************************************************
	assign tb_sel = md_q[3:1];
	assign watchdog_enable = md_q[`CCA_WATCHDOG_ENABLE_BIT];
	assign div_last = (tb_sel == `CCA_TB_DIV4) ? `CCA_DIV4_LAST : `CCA_DIV12_LAST;

	// Prescaler free-runs so the tick rate is fixed
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_q <= 4'h0;
		end else if (div_q >= div_last) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	// Watchdog keeps the counter running even when stopped
	assign tick = (cr_q | watchdog_enable) & (((tb_sel == `CCA_TB_DIV12) & (div_q == div_last)) |
		((tb_sel == `CCA_TB_DIV4) & (div_q == div_last)) |
		((tb_sel == `CCA_TB_EXT) & fall[6]) |
		(tb_sel == `CCA_TB_SYS));

	// ************************************************
	// Counter
	// ************************************************

	// Software byte writes take priority over counting
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= `CCA_CNT_RST;
			tick_q <= 1'b0;
			ovf_q <= 1'b0;
			lo_ovf_q <= 1'b0;
		end else begin
			tick_q <= tick;
			ovf_q <= tick & (cnt_q == 16'hFFFF);
			lo_ovf_q <= tick & (cnt_q[7:0] == 8'hFF);
			if (sfr_wr && sfr_addr == `CCA_CNT_LO_ADDR) begin
				cnt_q[7:0] <= sfr_wdata;
			end else if (sfr_wr && sfr_addr == `CCA_CNT_HI_ADDR) begin
				cnt_q[15:8] <= sfr_wdata;
			end else if (tick) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// ************************************************
	// Capture/compare modules
	// ************************************************
	genvar i;
	generate
		for (i = 0; i < 6; i = i + 1) begin : g_mod
			reg [7:0] mode_q; // Mode register
			reg [7:0] lo_q; // Compare low byte
			reg [7:0] hi_q; // Compare high byte
			reg out_q; // Pin level
			wire dog; // Module taken by watchdog
			wire [7:0] m; // Effective mode bits
			wire pwm; // Modulation on
			wire freq; // Frequency output
			wire narrow; // Low byte comparison
			wire m16; // Full match on fresh count
			wire m8; // Low byte match on fresh count
			wire hit; // Comparator hit
			wire cap; // Capture edge

			// Watchdog overrides every module five function
			assign dog = (i == 5) && watchdog_enable;
			assign m = dog ? 8'h00 : mode_q;
			assign pwm = m[`CCA_PWM_BIT];
			assign freq = pwm & m[`CCA_TOG_BIT];
			// Eight-bit modulation and frequency mode compare low byte only
			assign narrow = pwm & (~m[`CCA_WIDE_BIT] | m[`CCA_TOG_BIT]);
			assign m16 = tick_q & (cnt_q == {hi_q, lo_q});
			assign m8 = tick_q & (cnt_q[7:0] == lo_q);
			assign hit = m[`CCA_CMP_EN_BIT] & (narrow ? m8 : m16);
			assign cap = (m[`CCA_RISE_BIT] & rise[i]) |
				(m[`CCA_FALL_BIT] & fall[i]);
			assign flag_set[i] = cap | (m[`CCA_MATCH_BIT] & hit);
			assign irq_en[i] = m[`CCA_IRQ_EN_BIT];
			assign mode_all[i*8 +: 8] = mode_q;
			assign lo_all[i*8 +: 8] = lo_q;
			assign hi_all[i*8 +: 8] = hi_q;
			assign out_d[i] = out_q;

			// Mode register, plain read/write
			always @(posedge core_clk or posedge rst) begin
				if (rst) begin
					mode_q <= `CCA_MODE_RST;
				end else if (sfr_wr && mode_idx(sfr_addr) == i) begin
					mode_q <= sfr_wdata;
				end
			end

			// Compare bytes; a capture beats a software write
			always @(posedge core_clk or posedge rst) begin
				if (rst) begin
					lo_q <= `CCA_BYTE_RST;
					hi_q <= `CCA_BYTE_RST;
				end else if (cap) begin
					lo_q <= cnt_q[7:0];
					hi_q <= cnt_q[15:8];
				end else begin
					if (sfr_wr && lo_idx(sfr_addr) == i) begin
						lo_q <= sfr_wdata;
					end else if (freq && hit) begin
						// Next half period lies one high byte ahead
						lo_q <= lo_q + hi_q;
					end else if (pwm && narrow && !freq && lo_ovf_q) begin
						lo_q <= hi_q;
					end
					if (sfr_wr && hi_idx(sfr_addr) == i) begin
						// Watchdog update: deadline is now plus offset
						hi_q <= dog ? cnt_q[15:8] + lo_q : sfr_wdata;
					end
				end
			end

			// Pin driver for toggle, modulation and frequency modes
			always @(posedge core_clk or posedge rst) begin
				if (rst) begin
					out_q <= 1'b0;
				end else if (freq) begin
					if (hit) begin
						out_q <= ~out_q;
					end
				end else if (pwm) begin
					// Set beats clear so a zero compare stays high
					if (hit) begin
						out_q <= 1'b1;
					end else if (narrow ? lo_ovf_q : ovf_q) begin
						out_q <= 1'b0;
					end
				end else if (m[`CCA_TOG_BIT] && hit) begin
					out_q <= ~out_q;
				end
			end
		end
	endgenerate

	// ************************************************
	// Control and flag register
	// ************************************************

	// Hardware set wins over a software clear in the same cycle
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cf_q <= 1'b0;
			cr_q <= 1'b0;
			flag_q <= 6'h00;
		end else begin
			if (sfr_wr && sfr_addr == `CCA_CN_ADDR) begin
				cr_q <= sfr_wdata[`CCA_CR_BIT];
				cf_q <= sfr_wdata[`CCA_CF_BIT] | ovf_q;
				flag_q <= sfr_wdata[5:0] | flag_set;
			end else begin
				cf_q <= cf_q | ovf_q;
				flag_q <= flag_q | flag_set;
			end
		end
	end

	// ************************************************
	// Mode register with watchdog lock
	// ************************************************

	// While the watchdog runs only its enable may change
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			md_q <= `CCA_MD_RST;
		end else if (sfr_wr && sfr_addr == `CCA_MD_ADDR) begin
			if (!watchdog_enable) begin
				md_q <= {sfr_wdata[7:5], 1'b0, sfr_wdata[3:0]};
			end else if (!md_q[`CCA_WDLCK_BIT]) begin
				md_q[`CCA_WATCHDOG_ENABLE_BIT] <= sfr_wdata[`CCA_WATCHDOG_ENABLE_BIT];
			end
		end
	end

	// ************************************************
	// Outputs
	// ************************************************

	// Request only through unmasked flags
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
			module_output_pin <= 6'h00;
			wdt_reset_q <= 1'b0;
		end else begin
			irq_q <= (cf_q & md_q[`CCA_ECF_BIT]) | (|(flag_q & irq_en));
			module_output_pin <= out_d;
			// Timeout when counter reaches the deadline high byte
			wdt_reset_q <= watchdog_enable & tick_q & (cnt_q[15:8] == hi_all[47:40]) &
				(cnt_q[7:0] == 8'h00);
		end
	end

	// ************************************************
	// Read path
	// ************************************************
	assign rd_m = mode_idx(sfr_addr);
	assign rd_l = lo_idx(sfr_addr);
	assign rd_h = hi_idx(sfr_addr);

	// Unmapped addresses read zero
	always @* begin
		rd_d = 8'h00;
		if (rd_m != `CCA_NO_IDX) begin
			rd_d = mode_all[{rd_m, 3'b000} +: 8];
		end else if (rd_l != `CCA_NO_IDX) begin
			rd_d = lo_all[{rd_l, 3'b000} +: 8];
		end else if (rd_h != `CCA_NO_IDX) begin
			rd_d = hi_all[{rd_h, 3'b000} +: 8];
		end else begin
			case (sfr_addr)
				`CCA_CN_ADDR: rd_d = {cf_q, cr_q, flag_q};
				`CCA_MD_ADDR: rd_d = md_q;
				`CCA_CNT_LO_ADDR: rd_d = cnt_q[7:0];
				`CCA_CNT_HI_ADDR: rd_d = cnt_q[15:8];
				default: rd_d = 8'h00;
			endcase
		end
	end

	// Read data registered, held between reads
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata_q <= rd_d;
		end
	end

endmodule

// file: dv/cca_chk.sv
// Port checker for the counter array top.
// Assumes it is bound to cca_top and sees only its ports.
`timescale 1ns/1ps
module cca_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata_q,
	input wire logic [5:0] module_input,
	input wire logic ext_count_in,
	input wire logic [5:0] module_output_pin,
	input wire logic irq_q,
	input wire logic wdt_reset_q
);
	// ************************************************
	// Software copies of written registers
	// ************************************************
	logic [7:0] m_q [0:5]; // Mode copies
	logic [7:0] cl0_q; // Compare low 0 copy
	logic m0b_q; // Module 0 may rewrite its compare
	logic wd_q; // Watchdog believed on
	logic ecf_q; // Overflow request ever enabled
	int ri_q; // Mode index of last access
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// Mode address to index, 7 when not a mode register
	function automatic int idx(input logic [7:0] a);
		idx = (a == 8'hCE) ? 5 : (a >= 8'hDA && a <= 8'hDE) ? int'(a - 8'hDA) : 7;
	endfunction
	// Follow writes; capture or modulation may rewrite compare bytes, so guard them
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 6; i++)
				m_q[i] <= 8'h00;
			cl0_q <= 8'h00;
			m0b_q <= 1'b0;
			wd_q <= 1'b1;
			ecf_q <= 1'b0;
			ri_q <= 7;
		end else begin
			ri_q <= idx(sfr_addr);
			if (sfr_wr && idx(sfr_addr) < 6)
				m_q[idx(sfr_addr)] <= sfr_wdata;
			if (sfr_wr && sfr_addr == 8'hDA && (sfr_wdata[5:4] != 2'h0 || sfr_wdata[1]))
				m0b_q <= 1'b1;
			if (sfr_wr && sfr_addr == 8'hFB)
				cl0_q <= sfr_wdata;
			if (sfr_wr && sfr_addr == 8'hD9) begin
				wd_q <= sfr_wdata[6];
				ecf_q <= ecf_q | (sfr_wdata[0] & ~wd_q);
			end
		end
	end
	// ************************************************
	// Assertions
	// ************************************************
	a_rd_hold: assert property (
		!sfr_rd |=> $stable(sfr_rdata_q)) else $error("read data moved without a read");
	a_mode_readback: assert property (
		sfr_rd && !sfr_wr && idx(sfr_addr) < 6 |=> sfr_rdata_q == m_q[ri_q]) else $error("mode read differs");
	a_unmapped_zero: assert property (
		sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata_q == 8'h00) else $error("unmapped read not zero");
	a_cmp_readback: assert property (
		sfr_rd && !sfr_wr && sfr_addr == 8'hFB && !m0b_q |=> sfr_rdata_q == cl0_q) else $error("compare low differs");
	a_wdt_pulse: assert property (
		wdt_reset_q |=> !wdt_reset_q) else $error("watchdog pulse too long");
	a_wdt_gated: assert property (
		wdt_reset_q |-> $past(wd_q) || $past(wd_q, 2)) else $error("watchdog pulse while off");
	a_irq_masked: assert property (
		irq_q |-> ($past(m_q[0][0] | m_q[1][0] | m_q[2][0] | m_q[3][0] | m_q[4][0] | m_q[5][0]) || ecf_q))
		else $error("request with all enables clear");
	for (genvar k = 0; k < 6; k++) begin : g_pin
		a_pin_quiet: assert property (
			$changed(module_output_pin[k]) |-> $past(m_q[k][2:1]) != 2'h0 || $past(m_q[k][2:1], 2) != 2'h0
			|| $past(m_q[k][2:1], 3) != 2'h0) else $error("pin moved without toggle or modulation");
	end
endmodule
bind cca_top cca_chk chk_u (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .module_input(module_input),
	.ext_count_in(ext_count_in), .module_output_pin(module_output_pin), .irq_q(irq_q),
	.wdt_reset_q(wdt_reset_q));

// file: dv/cca_pins.sv
// Pin-side model: drives capture inputs, watches module output pin 0.
// Assumes the bench calls set_inputs and ext_pulses; external count idles high.
`timescale 1ns/1ps
module cca_pins (
	input wire logic core_clk,
	output logic [5:0] module_input,
	output logic ext_count_in,
	input wire logic [5:0] module_output_pin
);
	int pin0_edges; // Level changes seen on pin 0
	logic pin0_last; // Pin 0 at last edge
	// Quiet pins at start
	initial begin
		module_input = 6'h00;
		ext_count_in = 1'b1;
		pin0_edges = 0;
		pin0_last = 1'b0;
	end
	// Count changes so the bench can judge output frequency
	always @(posedge core_clk) begin
		if (module_output_pin[0] !== pin0_last)
			pin0_edges <= pin0_edges + 1;
		pin0_last <= module_output_pin[0];
	end
	// New input levels just after an edge, like a real board
	task automatic set_inputs(input logic [5:0] v);
		@(posedge core_clk);
		#1;
		module_input = v;
	endtask
	// Low pulses on the external count, slow enough for the synchroniser
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			ext_count_in = 1'b0;
			repeat (4) @(posedge core_clk);
			#1;
			ext_count_in = 1'b1;
			repeat (3) @(posedge core_clk);
		end
	endtask
endmodule

// file: dv/test_counter_array_capture_compare.sv
// Register-level bench for the counter array.
// Assumes the register port answers one cycle after each strobe.
`timescale 1ns/1ps
module test_counter_array_capture_compare;
	logic core_clk, rst, sfr_wr, sfr_rd;
	logic [7:0] sfr_addr, sfr_wdata, d;
	wire [7:0] sfr_rdata_q;
	wire [5:0] module_input, module_output_pin;
	wire ext_count_in, irq_q, wdt_reset_q;
	int n_mismatch, n_tests, cyc, e0, nw;
	logic [7:0] ma [0:5] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hCE}; // Mode addresses
	logic [7:0] la [0:5] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hD2}; // Compare low
	logic [7:0] ha [0:5] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hD3}; // Compare high
	cca_top dut_u (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .module_input(module_input),
		.ext_count_in(ext_count_in), .module_output_pin(module_output_pin), .irq_q(irq_q),
		.wdt_reset_q(wdt_reset_q));
	cca_pins pm_u (.core_clk(core_clk), .module_input(module_input), .ext_count_in(ext_count_in),
		.module_output_pin(module_output_pin));
	// 40 MHz clock
	always #12.5 core_clk = ~core_clk;
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		#1;
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(posedge core_clk);
		#1;
		sfr_wr = 1'b0;
	endtask
	// One-cycle read strobe; data is registered at the taking edge
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge core_clk);
		#1;
		sfr_rd = 1'b0;
		d = sfr_rdata_q;
		chk(d, exp);
	endtask
	task automatic pins(input logic [7:0] mask, input logic [7:0] exp);
		chk({2'h0, module_output_pin} & mask, exp);
	endtask
	task automatic test_done();
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		repeat (20) @(posedge core_clk);
		#1;
		rst = 1'b0;
		rc(8'hF9, 8'h00);
		rc(8'hFA, 8'h00);
		for (int i = 0; i < 6; i++) begin
			rc(ma[i], 8'h00);
			rc(ha[i], 8'h00);
		end
		// Watchdog off first, then system clock timebase
		wr(8'hD9, 8'h00);
		wr(8'hD9, 8'h08);
		rc(8'h00, 8'h00);
		wr(8'hF9, 8'h34);
		wr(8'hFA, 8'h12);
		rc(8'hF9, 8'h34);
		rc(8'hFA, 8'h12);
		for (int i = 0; i < 6; i++) begin
			wr(ma[i], 8'h81 + 8'(i * 4));
			wr(la[i], 8'h10 + 8'(i));
			wr(ha[i], 8'hE0 + 8'(i));
			rc(ma[i], 8'h81 + 8'(i * 4));
			rc(la[i], 8'h10 + 8'(i));
			rc(ha[i], 8'hE0 + 8'(i));
			wr(ma[i], 8'h00);
		end
		// Match: module 0 enabled, module 1 lacks comparator enable
		wr(8'hFB, 8'h10);
		wr(8'hFC, 8'h00);
		wr(8'hE9, 8'h10);
		wr(8'hEA, 8'h00);
		wr(8'hF9, 8'h00);
		wr(8'hFA, 8'h00);
		wr(8'hDA, 8'h4D);
		wr(8'hDB, 8'h0C);
		wr(8'hD8, 8'h40);
		repeat (30) @(posedge core_clk);
		rc(8'hD8, 8'h41);
		chk({7'h00, irq_q}, 8'h01);
		pins(8'h03, 8'h01);
		repeat (5) @(posedge core_clk);
		rc(8'hD8, 8'h41);
		wr(8'hDA, 8'h4C);
		repeat (3) @(posedge core_clk);
		chk({7'h00, irq_q}, 8'h00);
		wr(8'hD8, 8'h40);
		rc(8'hD8, 8'h40);
		// Frequency output: low match every 0x10 counts
		wr(8'hD8, 8'h00);
		wr(8'hF9, 8'h00);
		wr(8'hFA, 8'h00);
		wr(8'hFB, 8'h04);
		wr(8'hFC, 8'h10);
		wr(8'hDA, 8'h46);
		e0 = pm_u.pin0_edges;
		wr(8'hD8, 8'h40);
		repeat (60) @(posedge core_clk);
		chk(8'(pm_u.pin0_edges - e0), 8'h04);
		wr(8'hD8, 8'h00);
		wr(8'hDA, 8'h00);
		wr(8'hDB, 8'h00);
		// Capture: module 2 rising only, module 3 falling only
		wr(8'hF9, 8'h34);
		wr(8'hFA, 8'h12);
		wr(8'hDC, 8'h20);
		wr(8'hDD, 8'h10);
		pm_u.set_inputs(6'h0C);
		repeat (8) @(posedge core_clk);
		rc(8'hD8, 8'h04);
		rc(8'hEB, 8'h34);
		rc(8'hEC, 8'h12);
		wr(8'hD8, 8'h00);
		pm_u.set_inputs(6'h00);
		repeat (8) @(posedge core_clk);
		rc(8'hD8, 8'h08);
		rc(8'hED, 8'h34);
		rc(8'hEE, 8'h12);
		wr(8'hD8, 8'h00);
		wr(8'hDC, 8'h00);
		wr(8'hDD, 8'h00);
		// Modulation: module 4 wide, module 5 narrow, both at 0xF8
		wr(8'hFD, 8'hF8);
		wr(8'hFE, 8'h00);
		wr(8'hD2, 8'hF8);
		wr(8'hD3, 8'hF8);
		wr(8'hF9, 8'hF0);
		wr(8'hFA, 8'h00);
		wr(8'hDE, 8'hC2);
		wr(8'hCE, 8'h42);
		wr(8'hD8, 8'h40);
		repeat (14) @(posedge core_clk);
		pins(8'h30, 8'h30);
		repeat (10) @(posedge core_clk);
		pins(8'h30, 8'h10);
		// Overflow from 0xFFFF clears the wide pin and sets the flag
		wr(8'hD8, 8'h00);
		wr(8'hF9, 8'hF0);
		wr(8'hFA, 8'hFF);
		wr(8'hD8, 8'h40);
		repeat (30) @(posedge core_clk);
		pins(8'h10, 8'h00);
		rc(8'hD8, 8'hC0);
		chk(d & 8'h80, 8'h80);
		// Overflow request once its enable is set
		wr(8'hD9, 8'h09);
		repeat (2) @(posedge core_clk);
		chk({7'h00, irq_q}, 8'h01);
		// External timebase counts settled falling edges only
		wr(8'hD8, 8'h00);
		wr(8'hF9, 8'h00);
		wr(8'hFA, 8'h00);
		wr(8'hD9, 8'h06);
		wr(8'hD8, 8'h40);
		pm_u.ext_pulses(5);
		repeat (4) @(posedge core_clk);
		rc(8'hF9, 8'h05);
		// Watchdog: deadline is counter high byte plus module five low byte
		wr(8'hD8, 8'h00);
		wr(8'hCE, 8'h00);
		wr(8'hD2, 8'h02);
		wr(8'hF9, 8'h00);
		wr(8'hFA, 8'h10);
		wr(8'hD9, 8'h48);
		wr(8'hD3, 8'h00);
		rc(8'hD3, 8'h12);
		// One pulse as the counter passes the deadline, none after
		nw = 0;
		repeat (600) begin
			@(posedge core_clk);
			#1;
			nw = nw + int'(wdt_reset_q);
		end
		chk(8'(nw), 8'h01);
		test_done();
	end
endmodule
